/* File: rtl/ssx_cfg.svh */
// Offsets, field positions and reset values of the subtract/xor/swap/sleep datapath.
// Assumes inclusion by bare name from the package and the core.
`ifndef SSX_CFG_SVH
`define SSX_CFG_SVH

// -------------------------------------------------------------------
// Register byte offsets
// -------------------------------------------------------------------
`define SSX_OFF_CMD       12'h000
`define SSX_OFF_ACC       12'h004
`define SSX_OFF_STATUS    12'h008
`define SSX_OFF_CTRL      12'h00C
`define SSX_OFF_DIR_A     12'h010
`define SSX_OFF_DIR_B     12'h014
`define SSX_OFF_DIR_C     12'h018
`define SSX_OFF_WDT       12'h01C
`define SSX_MEM_BASE_BIT  9

// -------------------------------------------------------------------
// Field positions
// -------------------------------------------------------------------
`define SSX_CMD_OP_MSB    15
`define SSX_CMD_OP_LSB    12
`define SSX_CMD_DEST_BIT  8
`define SSX_ST_C          0
`define SSX_ST_DC         1
`define SSX_ST_Z          2
`define SSX_ST_TO_N       3
`define SSX_ST_PD_N       4
`define SSX_ST_SLEEP      5
`define SSX_ST_BUSY       6
`define SSX_CTRL_WDT_EN   0
`define SSX_CTRL_WAKE     1

// -------------------------------------------------------------------
// Operand codes and reset values
// -------------------------------------------------------------------
`define SSX_SEL_DIR_A     8'h05
`define SSX_SEL_DIR_B     8'h06
`define SSX_SEL_DIR_C     8'h07
`define SSX_ACC_RST       8'h00
`define SSX_DIR_RST       8'hFF
`define SSX_WDT_RST       8'h00

`endif

/* File: rtl/ssx_pkg.sv */
// Types shared by the datapath core.
// Assumes ssx_cfg.svh on the include path.
`include "ssx_cfg.svh"
package ssx_pkg;
    typedef enum logic [3:0] {
        OP_LIT_SUB  = 4'h1,
        OP_FILE_SUB = 4'h2,
        OP_FILE_SBB = 4'h3,
        OP_SWAP     = 4'h4,
        OP_XOR_LIT  = 4'h5,
        OP_XOR_FILE = 4'h6,
        OP_DIR_LOAD = 4'h7,
        OP_SLEEP    = 4'h8
    } ssx_op_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_EXEC = 3'b100
    } ssx_state_type;
endpackage

/* File: rtl/ssx_file_mem.sv */
// File register memory, one port, registered read data.
// Assumes one access per cycle chosen by the core.
`timescale 1ns/1ns
`default_nettype none
module ssx_file_mem #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[addr_i] <= wdata_i;
        end
    end

    // Read before write: the core never needs the new value at once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem_r[addr_i];
        end
    end
endmodule
`default_nettype wire

/* File: rtl/ssx_core.sv */
// Subtract, xor, nibble exchange, direction load and sleep datapath.
// Assumes a classic Wishbone master; one command runs at a time.
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "ssx_cfg.svh"
module ssx_core #(
    parameter int FILE_AW = 7,
    parameter int PRE_W   = 8
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic      [7:0]  port_a_direction_o,
    output logic      [7:0]  port_b_direction_o,
    output logic      [7:0]  port_c_direction_o,
    output logic             osc_run_o
);
    import ssx_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    ssx_state_type      state_r;
    logic [15:0]        cmd_r;
    logic [7:0]         acc_r;
    logic               c_r;
    logic               dc_r;
    logic               z_r;
    logic               to_n_r;
    logic               pd_n_r;
    logic               sleep_r;
    logic               wdt_en_r;
    logic [7:0]         watchdog_counter_r;
    logic [PRE_W-1:0]   pre_r;
    logic [7:0]         dir_a_r;
    logic [7:0]         dir_b_r;
    logic [7:0]         dir_c_r;
    logic               ack_r;
    logic               pend_r;
    logic [31:0]        dat_r;
    logic [7:0]         mem_rdata;
    logic [FILE_AW-1:0] mem_addr;
    logic [7:0]         mem_wdata;
    logic               mem_we;

    function automatic logic is_mem(input logic [11:0] adr);
        return adr[`SSX_MEM_BASE_BIT];
    endfunction

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    logic req;
    logic reg_wr;
    logic mem_ok;
    logic cmd_start;
    logic exec;
    assign req       = wb_cyc_i & wb_stb_i & ~ack_r & ~pend_r;
    assign reg_wr    = req & ~is_mem(wb_adr_i) & wb_we_i & wb_sel_i[0];
    assign mem_ok    = req & is_mem(wb_adr_i) & (state_r == ST_IDLE);
    // Commands while busy or asleep are dropped, not queued
    assign cmd_start = reg_wr & (wb_adr_i == `SSX_OFF_CMD) & wb_sel_i[1]
                       & (state_r == ST_IDLE) & ~sleep_r;
    assign exec      = (state_r == ST_EXEC);

    // ---------------------------------------------------------------
    // Execute
    // ---------------------------------------------------------------
    ssx_op_type op;
    logic [7:0] lit;
    logic       dest;
    logic [7:0] opa;
    logic [7:0] opb;
    logic       cin;
    logic [8:0] diff9;
    logic [4:0] nib5;
    logic [7:0] res;
    logic       is_sub;
    logic       hits_z;
    logic       to_file;
    logic       to_acc;
    assign op   = ssx_op_type'(cmd_r[`SSX_CMD_OP_MSB:`SSX_CMD_OP_LSB]);
    assign lit  = cmd_r[7:0];
    assign dest = cmd_r[`SSX_CMD_DEST_BIT];

    always_comb begin
        opa     = mem_rdata;
        opb     = acc_r;
        cin     = 1'b1;
        res     = 8'h00;
        is_sub  = 1'b0;
        hits_z  = 1'b0;
        to_file = 1'b0;
        to_acc  = 1'b0;
        case (op)
            OP_LIT_SUB: begin
                opa    = lit;
                is_sub = 1'b1;
                to_acc = 1'b1;
            end
            OP_FILE_SUB: begin
                is_sub = 1'b1;
            end
            OP_FILE_SBB: begin
                is_sub = 1'b1;
                cin    = c_r;
            end
            OP_SWAP: begin
                res = {mem_rdata[3:0], mem_rdata[7:4]};
            end
            OP_XOR_LIT: begin
                res    = acc_r ^ lit;
                hits_z = 1'b1;
                to_acc = 1'b1;
            end
            OP_XOR_FILE: begin
                res    = acc_r ^ mem_rdata;
                hits_z = 1'b1;
            end
            default: begin
            end
        endcase
        // Subtraction as a + ~b + cin; carry out is the no-borrow flag
        diff9 = {1'b0, opa} + {1'b0, ~opb} + {8'h00, cin};
        nib5  = {1'b0, opa[3:0]} + {1'b0, ~opb[3:0]} + {4'h0, cin};
        if (is_sub) begin
            res    = diff9[7:0];
            hits_z = 1'b1;
        end
        if (op == OP_FILE_SUB || op == OP_FILE_SBB || op == OP_SWAP
            || op == OP_XOR_FILE) begin
            to_file = dest;
            to_acc  = ~dest;
        end
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            cmd_r   <= 16'h0000;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (cmd_start) begin
                        cmd_r   <= wb_dat_i[15:0];
                        state_r <= ST_READ;
                    end
                end
                ST_READ: state_r <= ST_EXEC;
                ST_EXEC: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // File memory port: core owns it whenever not idle
    always_comb begin
        mem_addr  = wb_adr_i[FILE_AW+1:2];
        mem_wdata = wb_dat_i[7:0];
        mem_we    = mem_ok & wb_we_i & wb_sel_i[0];
        if (state_r != ST_IDLE) begin
            mem_addr  = cmd_r[FILE_AW-1:0];
            mem_wdata = res;
            mem_we    = exec & to_file;
        end
    end

    ssx_file_mem #(.AW(FILE_AW), .DW(8)) i_ssx_file_mem (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (mem_we),
        .addr_i  (mem_addr),
        .wdata_i (mem_wdata),
        .rdata_o (mem_rdata)
    );

    // ---------------------------------------------------------------
    // Accumulator, arithmetic flags, direction registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_r <= `SSX_ACC_RST;
        end else if (exec && to_acc) begin
            acc_r <= res;
        end else if (reg_wr && wb_adr_i == `SSX_OFF_ACC) begin
            acc_r <= wb_dat_i[7:0];
        end
    end

    // Hardware update wins over a software write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c_r  <= 1'b0;
            dc_r <= 1'b0;
            z_r  <= 1'b0;
        end else if (exec && (is_sub || hits_z)) begin
            if (is_sub) begin
                c_r  <= diff9[8];
                dc_r <= nib5[4];
            end
            z_r <= (res == 8'h00);
        end else if (reg_wr && wb_adr_i == `SSX_OFF_STATUS) begin
            c_r  <= wb_dat_i[`SSX_ST_C];
            dc_r <= wb_dat_i[`SSX_ST_DC];
            z_r  <= wb_dat_i[`SSX_ST_Z];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_a_r <= `SSX_DIR_RST;
            dir_b_r <= `SSX_DIR_RST;
            dir_c_r <= `SSX_DIR_RST;
        end else if (exec && op == OP_DIR_LOAD) begin
            case (lit)
                `SSX_SEL_DIR_A: dir_a_r <= acc_r;
                `SSX_SEL_DIR_B: dir_b_r <= acc_r;
                `SSX_SEL_DIR_C: dir_c_r <= acc_r;
                default: begin
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Watchdog, sleep and power flags
    // ---------------------------------------------------------------
    logic do_sleep;
    logic wdt_ovf;
    assign do_sleep = exec & (op == OP_SLEEP);
    assign wdt_ovf  = wdt_en_r & (&pre_r) & (&watchdog_counter_r);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            watchdog_counter_r <= `SSX_WDT_RST;
            pre_r              <= '0;
        end else if (do_sleep) begin
            watchdog_counter_r <= `SSX_WDT_RST;
            pre_r              <= '0;
        end else if (wdt_en_r) begin
            pre_r <= pre_r + 1'b1;
            if (&pre_r) begin
                watchdog_counter_r <= watchdog_counter_r + 8'h01;
            end
        end
    end

    // Sleep wins over a wake or a time-out in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            to_n_r  <= 1'b1;
            pd_n_r  <= 1'b1;
            sleep_r <= 1'b0;
        end else if (do_sleep) begin
            to_n_r  <= 1'b1;
            pd_n_r  <= 1'b0;
            sleep_r <= 1'b1;
        end else begin
            if (wdt_ovf) begin
                to_n_r  <= 1'b0;
                sleep_r <= 1'b0;
            end
            if (reg_wr && wb_adr_i == `SSX_OFF_CTRL && wb_dat_i[`SSX_CTRL_WAKE]) begin
                sleep_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_en_r <= 1'b0;
        end else if (reg_wr && wb_adr_i == `SSX_OFF_CTRL) begin
            wdt_en_r <= wb_dat_i[`SSX_CTRL_WDT_EN];
        end
    end

    // ---------------------------------------------------------------
    // Bus answer
    // ---------------------------------------------------------------
    logic [31:0] reg_rd;
    logic [7:0]  st_byte;
    assign st_byte = {1'b0, (state_r != ST_IDLE), sleep_r, pd_n_r, to_n_r, z_r, dc_r, c_r};

    always_comb begin
        case (wb_adr_i)
            `SSX_OFF_CMD:    reg_rd = {16'h0000, cmd_r};
            `SSX_OFF_ACC:    reg_rd = {24'h000000, acc_r};
            `SSX_OFF_STATUS: reg_rd = {24'h000000, st_byte};
            `SSX_OFF_CTRL:   reg_rd = {31'h00000000, wdt_en_r};
            `SSX_OFF_DIR_A:  reg_rd = {24'h000000, dir_a_r};
            `SSX_OFF_DIR_B:  reg_rd = {24'h000000, dir_b_r};
            `SSX_OFF_DIR_C:  reg_rd = {24'h000000, dir_c_r};
            `SSX_OFF_WDT:    reg_rd = {24'h000000, watchdog_counter_r};
            default:         reg_rd = 32'h00000000;
        endcase
    end

    // Memory reads cost one extra cycle for the registered read port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            pend_r <= 1'b0;
            dat_r  <= 32'h00000000;
        end else begin
            ack_r <= 1'b0;
            if (pend_r) begin
                ack_r  <= 1'b1;
                pend_r <= 1'b0;
                dat_r  <= {24'h000000, mem_rdata};
            end else if (req && !is_mem(wb_adr_i)) begin
                ack_r <= 1'b1;
                dat_r <= reg_rd;
            end else if (mem_ok) begin
                ack_r  <= wb_we_i;
                pend_r <= ~wb_we_i;
            end
        end
    end

    assign wb_ack_o           = ack_r;
    assign wb_dat_o           = dat_r;
    assign port_a_direction_o = dir_a_r;
    assign port_b_direction_o = dir_b_r;
    assign port_c_direction_o = dir_c_r;
    assign osc_run_o          = ~sleep_r;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence run_s;
        state_r == ST_READ ##1 state_r == ST_EXEC ##1 state_r == ST_IDLE;
    endsequence

    cmd_seq_a: assert property (cmd_start |=> run_s)
        else $error("command did not run read then execute");
    lit_sub_a: assert property (exec && op == OP_LIT_SUB
        |=> acc_r == 8'($past(lit) - $past(acc_r)))
        else $error("literal minus accumulator wrong");
    file_sub_a: assert property (exec && op == OP_FILE_SUB && !dest
        |=> acc_r == 8'($past(mem_rdata) - $past(acc_r)))
        else $error("file minus accumulator wrong");
    sub_carry_a: assert property (exec && (op == OP_LIT_SUB || op == OP_FILE_SUB)
        |=> c_r == ($past(opb) <= $past(opa))
            && dc_r == ($past(opb[3:0]) <= $past(opa[3:0])))
        else $error("subtract carry flags wrong");
    borrow_sub_a: assert property (exec && op == OP_FILE_SBB && !dest
        |=> acc_r == 8'($past(mem_rdata) - $past(acc_r) - {7'h00, !$past(c_r)}))
        else $error("borrow subtract wrong");
    dest_file_a: assert property (exec && to_file
        |-> mem_we ##1 $stable(acc_r))
        else $error("file destination not honoured");
    swap_keep_a: assert property (exec && op == OP_SWAP
        |=> $stable({c_r, dc_r, z_r}))
        else $error("nibble exchange touched flags");
    xor_lit_a: assert property (exec && op == OP_XOR_LIT
        |=> acc_r == ($past(acc_r) ^ $past(lit)) && $stable({c_r, dc_r}))
        else $error("literal xor wrong");
    xor_file_a: assert property (exec && op == OP_XOR_FILE && dest
        |-> mem_wdata == (acc_r ^ mem_rdata) ##1 $stable({c_r, dc_r}))
        else $error("file xor wrong");
    dir_load_a: assert property (exec && op == OP_DIR_LOAD && lit == `SSX_SEL_DIR_B
        |=> dir_b_r == $past(acc_r) && $stable(dir_a_r) && $stable(z_r))
        else $error("direction load wrong");
    sleep_wdt_a: assert property (do_sleep
        |=> watchdog_counter_r == 8'h00 && pre_r == '0)
        else $error("sleep left watchdog running");
    sleep_flags_a: assert property (do_sleep
        |=> to_n_r && !pd_n_r && !osc_run_o)
        else $error("sleep flags wrong");
    zero_flag_a: assert property (exec && hits_z
        |=> z_r == ($past(res) == 8'h00))
        else $error("zero flag wrong");
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the subtract/xor/swap/sleep datapath core.
// Assumes ssx_pkg compiled first and ssx_cfg.svh on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "ssx_cfg.svh"
module testbench;
    import ssx_pkg::*;

    localparam int LIMIT = 8000;

    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [7:0]  port_a_direction_o;
    logic [7:0]  port_b_direction_o;
    logic [7:0]  port_c_direction_o;
    logic        osc_run_o;
    int          num_errors;
    int          checks_done;
    int          cyc_count;

    // Short prescaler keeps the watchdog overflow near a thousand cycles
    ssx_core #(.FILE_AW(7), .PRE_W(2)) i_ssx_core (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_a_direction_o(port_a_direction_o),
        .port_b_direction_o(port_b_direction_o), .port_c_direction_o(port_c_direction_o),
        .osc_run_o(osc_run_o));

    always #2 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == LIMIT) begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end

    // -------------------------------------------------------------------
    // Bus and compare helpers
    // -------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            num_errors = num_errors + 1;
        end
    endtask

    // Request held until ack is sampled high; one idle cycle before the next
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'hF, q);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, 4'hF, q);
    endtask

    // Issue one command and poll until busy drops
    task automatic run(input ssx_op_type op, input logic d, input logic [7:0] arg);
        logic [31:0] q;
        wr(`SSX_OFF_CMD, {16'h0, op, 3'b000, d, arg});
        for (int n = 0; n < 10; n++) begin
            rd(`SSX_OFF_STATUS, q);
            if (q[6] === 1'b0) break;
        end
        chk({31'h0, q[6]}, 32'h0);
    endtask

    // Preset file byte, accumulator and flags, run, compare with the reference
    task automatic do_op(input ssx_op_type op, input logic d, input logic [7:0] arg,
                         input logic [7:0] fv, input logic [7:0] av, input logic [2:0] pf);
        logic [31:0] q;
        logic [11:0] fa;
        logic [8:0]  r9;
        logic [4:0]  r5;
        logic [7:0]  res;
        logic [7:0]  m;
        logic [7:0]  ea;
        logic [7:0]  ef;
        logic [2:0]  fl;
        logic        b;
        fa = 12'h200 + {3'b000, arg[6:0], 2'b00};
        m  = (op == OP_LIT_SUB) ? arg : fv;
        b  = (op == OP_FILE_SBB) ? ~pf[0] : 1'b0;
        r9 = {1'b0, m} - {1'b0, av} - {8'h00, b};
        r5 = {1'b0, m[3:0]} - {1'b0, av[3:0]} - {4'h0, b};
        fl = pf;
        ea = av;
        ef = fv;
        case (op)
            OP_LIT_SUB, OP_FILE_SUB, OP_FILE_SBB: begin
                res = r9[7:0];
                fl  = {res == 8'h00, ~r5[4], ~r9[8]};
            end
            OP_SWAP: res = {fv[3:0], fv[7:4]};
            OP_XOR_LIT: begin
                res   = av ^ arg;
                fl[2] = (res == 8'h00);
            end
            default: begin
                res   = av ^ fv;
                fl[2] = (res == 8'h00);
            end
        endcase
        if (op == OP_LIT_SUB || op == OP_XOR_LIT || !d) ea = res;
        else ef = res;
        wr(fa, {24'h0, fv});
        wr(`SSX_OFF_ACC, {24'h0, av});
        wr(`SSX_OFF_STATUS, {29'h0, pf});
        run(op, d, arg);
        rd(`SSX_OFF_ACC, q);
        chk(q, {24'h0, ea});
        rd(fa, q);
        chk(q, {24'h0, ef});
        rd(`SSX_OFF_STATUS, q);
        chk(q, {24'h0, 5'b00011, fl});
    endtask

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    task automatic t_basic;
        logic [31:0] q;
        chk({port_a_direction_o, port_b_direction_o, port_c_direction_o, 8'h0}, 32'hFFFFFF00);
        chk({31'h0, osc_run_o}, 32'h1);
        rd(`SSX_OFF_STATUS, q);
        chk(q, 32'h18);
        wr(12'h020, 32'hFF);
        rd(12'h020, q);
        chk(q, 32'h0);
        // Write without the low byte enable must not land
        wb(1'b1, `SSX_OFF_ACC, 32'h77, 4'h2, q);
        rd(`SSX_OFF_ACC, q);
        chk(q, 32'h0);
    endtask

    task automatic t_sub;
        do_op(OP_LIT_SUB, 1'b0, 8'h25, 8'h00, 8'h30, 3'b000);
        do_op(OP_LIT_SUB, 1'b1, 8'h25, 8'h00, 8'h25, 3'b001);
        do_op(OP_FILE_SUB, 1'b0, 8'h7F, 8'h18, 8'h09, 3'b000);
        do_op(OP_FILE_SUB, 1'b1, 8'h00, 8'h00, 8'h01, 3'b111);
    endtask

    task automatic t_sbb;
        do_op(OP_FILE_SBB, 1'b1, 8'h10, 8'h50, 8'h20, 3'b000);
        do_op(OP_FILE_SBB, 1'b0, 8'h10, 8'h21, 8'h20, 3'b000);
        do_op(OP_FILE_SBB, 1'b0, 8'h11, 8'h21, 8'h20, 3'b001);
        do_op(OP_FILE_SBB, 1'b1, 8'h12, 8'h10, 8'h01, 3'b001);
    endtask

    task automatic t_swap_xor;
        do_op(OP_SWAP, 1'b0, 8'h33, 8'hA5, 8'h00, 3'b101);
        do_op(OP_SWAP, 1'b1, 8'h7F, 8'h0F, 8'h11, 3'b010);
        do_op(OP_XOR_LIT, 1'b1, 8'h5A, 8'h00, 8'h5A, 3'b011);
        do_op(OP_XOR_LIT, 1'b0, 8'hFF, 8'h00, 8'h0F, 3'b100);
        do_op(OP_XOR_FILE, 1'b0, 8'h02, 8'hC3, 8'h3C, 3'b000);
        do_op(OP_XOR_FILE, 1'b1, 8'h03, 8'h66, 8'h66, 3'b011);
    endtask

    task automatic t_dir;
        logic [31:0] q;
        logic [7:0]  e [3];
        e = '{8'hFF, 8'hFF, 8'hFF};
        wr(`SSX_OFF_STATUS, 32'h5);
        for (int i = 4; i < 8; i++) begin
            wr(`SSX_OFF_ACC, {24'h0, 4'(i), 4'(~i)});
            run(OP_DIR_LOAD, 1'b0, 8'(i));
            if (i > 4) e[i-5] = {4'(i), 4'(~i)};
            chk({port_a_direction_o, port_b_direction_o, port_c_direction_o, 8'h0},
                {e[0], e[1], e[2], 8'h0});
            rd(`SSX_OFF_DIR_A + 12'(4 * (i % 3)), q);
            chk(q, {24'h0, e[i % 3]});
            rd(`SSX_OFF_STATUS, q);
            chk(q, 32'h1D);
        end
    endtask

    task automatic t_sleep;
        logic [31:0] q;
        wr(`SSX_OFF_CTRL, 32'h1);
        repeat (1100) @(posedge clk_i);
        rd(`SSX_OFF_STATUS, q);
        chk({31'h0, q[3]}, 32'h0);
        wr(`SSX_OFF_CTRL, 32'h0);
        wr(`SSX_OFF_STATUS, 32'h5);
        wr(`SSX_OFF_ACC, 32'h3C);
        run(OP_SLEEP, 1'b0, 8'h00);
        rd(`SSX_OFF_WDT, q);
        chk(q, 32'h0);
        rd(`SSX_OFF_STATUS, q);
        chk(q, 32'h2D);
        chk({31'h0, osc_run_o}, 32'h0);
        // Commands while asleep are acked but ignored
        wr(`SSX_OFF_CMD, {16'h0, OP_XOR_LIT, 4'h0, 8'hFF});
        rd(`SSX_OFF_ACC, q);
        chk(q, 32'h3C);
        wr(`SSX_OFF_CTRL, 32'h2);
        rd(`SSX_OFF_STATUS, q);
        chk(q & 32'h20, 32'h0);
        chk({31'h0, osc_run_o}, 32'h1);
    endtask

    // -------------------------------------------------------------------
    // Closing report and main sequence
    // -------------------------------------------------------------------
    task automatic end_sim;
        if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        clk_i       = 1'b0;
        rst_i       = 1'b1;
        wb_cyc_i    = 1'b0;
        wb_stb_i    = 1'b0;
        wb_we_i     = 1'b0;
        wb_adr_i    = 12'h000;
        wb_sel_i    = 4'h0;
        wb_dat_i    = 32'h0;
        num_errors  = 0;
        checks_done = 0;
        cyc_count   = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_basic();
        t_sub();
        t_sbb();
        t_swap_xor();
        t_dir();
        t_sleep();
        end_sim();
    end
endmodule
`default_nettype wire
